// ===== dqc_bus_if.sv
// Interface joining the counter's parallel host bus with the host controller.
`timescale 1ns/1ps
`default_nettype none
interface dqc_bus_if;
  // Strobes and selects, all driven by the host.
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic cd;
  logic xy;
  // Each party's data drive and enable.
  logic [7:0] host_d;
  logic host_oe;
  logic [7:0] dev_d;
  logic dev_oe;
  // Resolved bus level; an undriven bus floats high as through pull-ups.
  logic [7:0] data;
  assign data = dev_oe ? dev_d : (host_oe ? host_d : 8'hFF);
  modport dev (input cs_n, rd_n, wr_n, cd, xy, data, output dev_d, dev_oe);
  modport host (output cs_n, rd_n, wr_n, cd, xy, host_d, host_oe, input data);
endinterface
`default_nettype wire

// ===== dqc_dev.sv
// Dual axis 24-bit quadrature counter with its parallel host bus.
// Notes on behaviour
// - Quadrature inputs filtered then decoded into counts.
// - Non-quadrature mode skips filter and decoder.
// - Non-quadrature: A clocks, B high counts up.
// - Load input: direct or synchronous, counter or latch.
// - Direct load low; synchronous level programmable.
// - Index works for quarter or half cycles.
// - Host disables index in non-quadrature mode.
// - Reset input: direct reset, gate, or index.
// - Gate high enables counting, low disables.
// - Flag one: carry, compare, index, carry/borrow.
// - Flag two: borrow or direction; ior bit 5 is always 0, so never the noise bit.
// - Bytes captured at rising edge of write.
// - Read low drives status or latch byte.
// - Only chip select low accesses respond.
// - Control/data select: low data, high control.
// - Eight-bit bus released when not reading.
// - One eight-bit prescaler per axis.
// - Axis select: zero X, one Y.
// - Filter clock period is n+1 base periods.
// - Quadrature edge counts after five to six periods.
// - Data byte accesses advance the byte index.
// - Control writes decode bits 7 to 5.
// - Noise bit sticky until reset/load command.
`timescale 1ns/1ps
`default_nettype none
module dqc_dev (
  // Clock, clock enable and reset; clk_i is also the filter base clock.
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic rst_i,
  // Host bus.
  dqc_bus_if.dev bus,
  // Encoder pins, index 0 is the X axis and index 1 the Y axis.
  input wire logic [1:0] count_input_a_i,
  input wire logic [1:0] count_input_b_i,
  input wire logic [1:0] load_index_input_i,
  input wire logic [1:0] reset_or_gate_input_i,
  // Programmable flag outputs.
  output wire logic [1:0] flag_out_one_o,
  output wire logic [1:0] flag_out_two_o
);
  import dqc_pkg::*;

  // Bus pins registered once; the host holds them steady around each strobe.
  logic cs_q;
  logic rd_q;
  logic wr_q;
  logic cd_q;
  logic xy_q;
  logic [7:0] d_q;
  // Per-axis latch and status, gathered for the read multiplexer.
  logic [23:0] snapshot_latch [2];
  logic [7:0] axis_status_byte [2];
  logic [1:0] byte_index [2];

  // Trailing edges of the strobes, qualified by chip select.
  logic wr_end;
  logic rd_end;
  assign wr_end = ~wr_q & bus.wr_n & ~cs_q;
  assign rd_end = ~rd_q & bus.rd_n & ~cs_q;

  // Sample the bus every enabled cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      cd_q <= 1'b0;
      xy_q <= 1'b0;
      d_q <= 8'h00;
    end else if (ce_i) begin
      cs_q <= bus.cs_n;
      rd_q <= bus.rd_n;
      wr_q <= bus.wr_n;
      cd_q <= bus.cd;
      xy_q <= bus.xy;
      d_q <= bus.data;
    end
  end

  // Read drive: one cycle after select and read are seen low, released one cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus.dev_oe <= 1'b0;
      bus.dev_d <= 8'h00;
    end else if (ce_i) begin
      bus.dev_oe <= ~bus.cs_n & ~bus.rd_n;
      if (bus.cd) begin
        bus.dev_d <= axis_status_byte[bus.xy];
      end else begin
        bus.dev_d <= snapshot_latch[bus.xy][8 * byte_index[bus.xy] +: 8];
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_axis
      logic [23:0] load_value_reg;
      logic [23:0] position_count;
      logic [7:0] filter_divider;
      logic [7:0] pcnt;
      logic axis_filter_clock;
      logic [1:0] mode;
      logic [5:0] ior;
      logic [2:0] index_setup_reg;
      logic [FILT_LEN-1:0] sa;
      logic [FILT_LEN-1:0] sb;
      logic [FILT_LEN-1:0] si;
      logic fa;
      logic fb;
      logic pa;
      logic pb;
      logic na;
      logic a_q;
      logic b_q;
      logic ld_q;
      logic rg_q;
      logic armed;
      logic cry_p;
      logic brw_p;
      logic cry_st;
      logic brw_st;
      logic direction_status_bit;
      logic noise_error_bit;
      logic flg1;
      logic flg2;
      logic mine;
      logic wr_ctl;
      logic wr_dat;
      logic step;
      logic up;
      logic achg;
      logic bchg;
      logic quad;
      logic idx_act;
      logic idx_hit;
      logic index_status_bit;
      logic [7:0] rlc;
      logic cmp;

      // Axis match; a control byte with bit 7 set hits both axes.
      assign mine = (xy_q == 1'(i));
      assign wr_ctl = wr_end & cd_q & (mine | d_q[CTL_BOTH_BIT]);
      assign wr_dat = wr_end & ~cd_q & mine;
      assign rlc = (wr_ctl && d_q[6:5] == SEL_RLC) ? d_q : 8'h00;
      assign quad = (mode != MODE_NONQ);
      assign cmp = (load_value_reg == position_count);

      // Index level: chosen pin, chosen polarity, from the synchronised chain.
      assign idx_act = (index_setup_reg[IXS_ON_RG] ? si[FILT_LEN-1] : si[FILT_LEN-2])
                       == index_setup_reg[IXS_POL_HI];
      assign index_status_bit = idx_act;

      // Mode registers written from control bytes.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mode <= MODE_NONQ;
          ior <= IOR_RST;
          index_setup_reg <= IXS_RST;
        end else if (ce_i && wr_ctl) begin
          if (d_q[6:5] == SEL_CMR) begin
            mode <= d_q[1:0];
          end
          if (d_q[6:5] == SEL_IOR) begin
            ior <= d_q[5:0];
          end
          if (d_q[6:5] == SEL_IXS) begin
            index_setup_reg <= d_q[2:0];
          end
        end
      end

      // Load value bytes and the byte index.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          load_value_reg <= CNT_RST;
          byte_index[i] <= 2'h0;
        end else if (ce_i) begin
          if (wr_dat) begin
            load_value_reg[8 * byte_index[i] +: 8] <= d_q;
          end
          if (rlc[RLC_RST_IDX]) begin
            byte_index[i] <= 2'h0;
          end else if (wr_dat || (rd_end && !cd_q && mine)) begin
            byte_index[i] <= (byte_index[i] == 2'h2) ? 2'h0 : byte_index[i] + 2'h1;
          end
        end
      end

      // Prescaler: a tick every filter_divider+1 base cycles.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          filter_divider <= DIV_RST;
          pcnt <= DIV_RST;
          axis_filter_clock <= 1'b0;
        end else if (ce_i) begin
          if (rlc[RLC_PR_CNT] && rlc[RLC_CNT_OL]) begin
            filter_divider <= load_value_reg[7:0];
          end
          axis_filter_clock <= (pcnt == 8'h00);
          pcnt <= (pcnt == 8'h00) ? filter_divider : pcnt - 8'h01;
        end
      end

      // Synchroniser pair then three agreeing samples; the first stage feeds only the second.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sa <= '0;
          sb <= '0;
          si <= '0;
          fa <= 1'b0;
          fb <= 1'b0;
        end else if (ce_i && axis_filter_clock) begin
          sa <= {sa[FILT_LEN-2:0], count_input_a_i[i]};
          sb <= {sb[FILT_LEN-2:0], count_input_b_i[i]};
          si <= {si[FILT_LEN-2:0], index_setup_reg[IXS_ON_RG] ? reset_or_gate_input_i[i]
                                                               : load_index_input_i[i]};
          if (sa[1] == sa[2] && sa[2] == sa[3]) begin
            fa <= sa[3];
          end
          if (sb[1] == sb[2] && sb[2] == sb[3]) begin
            fb <= sb[3];
          end
        end
      end

      // Plain pin samples for the bypass path and direct functions.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          a_q <= 1'b0;
          b_q <= 1'b0;
          na <= 1'b0;
          ld_q <= 1'b1;
          rg_q <= 1'b1;
        end else if (ce_i) begin
          a_q <= count_input_a_i[i];
          b_q <= count_input_b_i[i];
          na <= a_q;
          ld_q <= load_index_input_i[i];
          rg_q <= reset_or_gate_input_i[i];
        end
      end

      // Decoder: one count per filter tick; both phases moving at once is noise.
      assign achg = axis_filter_clock & (fa != pa);
      assign bchg = axis_filter_clock & (fb != pb);
      always_comb begin
        step = 1'b0;
        up = 1'b0;
        if (!quad) begin
          step = a_q & ~na;
          up = b_q;
        end else if (achg ^ bchg) begin
          up = achg ? (fa ^ fb) : ~(fa ^ fb);
          unique case (mode)
            MODE_X1: step = achg & ~fb;
            MODE_X2: step = achg;
            default: step = 1'b1;
          endcase
        end
        if (ior[IOR_GATE] && !(index_setup_reg[IXS_EN] && index_setup_reg[IXS_ON_RG])) begin
          step = step & rg_q;
        end
      end

      // Index fires on the first count edge while active, then rearms when inactive.
      assign idx_hit = index_setup_reg[IXS_EN] & quad & idx_act & armed & step;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          armed <= 1'b1;
          pa <= 1'b0;
          pb <= 1'b0;
        end else if (ce_i) begin
          if (axis_filter_clock) begin
            pa <= fa;
            pb <= fb;
          end
          if (idx_hit) begin
            armed <= 1'b0;
          end else if (!idx_act) begin
            armed <= 1'b1;
          end
        end
      end

      // Counter and latch: reset beats load, load beats counting.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          position_count <= CNT_RST;
          snapshot_latch[i] <= CNT_RST;
          cry_p <= 1'b0;
          brw_p <= 1'b0;
          direction_status_bit <= 1'b0;
        end else if (ce_i) begin
          cry_p <= 1'b0;
          brw_p <= 1'b0;
          if (rlc[RLC_CNT_OL] && !rlc[RLC_PR_CNT]) begin
            snapshot_latch[i] <= position_count;
          end else if (ior[IOR_LD_OL] && ((!index_setup_reg[IXS_EN] && !ld_q) ||
                       (idx_hit && !index_setup_reg[IXS_ON_RG]))) begin
            snapshot_latch[i] <= position_count;
          end
          if (rlc[RLC_RST_CNT] || (!ior[IOR_GATE] && !rg_q &&
              !(index_setup_reg[IXS_EN] && index_setup_reg[IXS_ON_RG])) ||
              (idx_hit && index_setup_reg[IXS_ON_RG])) begin
            position_count <= CNT_RST;
          end else if ((rlc[RLC_PR_CNT] && !rlc[RLC_CNT_OL]) || (!ior[IOR_LD_OL] &&
                       ((!index_setup_reg[IXS_EN] && !ld_q) ||
                       (idx_hit && !index_setup_reg[IXS_ON_RG])))) begin
            position_count <= load_value_reg;
          end else if (step) begin
            position_count <= up ? position_count + 24'h000001 : position_count - 24'h000001;
            cry_p <= up & (position_count == 24'hFFFFFF);
            brw_p <= ~up & (position_count == 24'h000000);
            direction_status_bit <= up;
          end
        end
      end

      // Sticky status bits; an event in the clearing cycle wins.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cry_st <= 1'b0;
          brw_st <= 1'b0;
          noise_error_bit <= 1'b0;
        end else if (ce_i) begin
          cry_st <= cry_p | (cry_st & ~rlc[RLC_RST_FLG]);
          brw_st <= brw_p | (brw_st & ~rlc[RLC_RST_FLG]);
          noise_error_bit <= (quad & achg & bchg) | (noise_error_bit & ~rlc[RLC_RST_FLG]);
        end
      end
      assign axis_status_byte[i] = {1'b0, index_status_bit, direction_status_bit,
                                    noise_error_bit, 1'b0, cmp, brw_st, cry_st};

      // Flag outputs, registered so each pin comes from a flip-flop.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flg1 <= FLG_RST;
          flg2 <= FLG_RST;
        end else if (ce_i) begin
          unique case (ior[IOR_F1_LSB +: 2])
            2'h0: flg1 <= ~cry_p;
            2'h1: flg1 <= ~cmp;
            2'h2: flg1 <= index_status_bit;
            2'h3: flg1 <= ~(cry_p | brw_p);
          endcase
          unique case (ior[IOR_F2_LSB +: 2])
            2'h0: flg2 <= ~brw_p;
            2'h1: flg2 <= direction_status_bit;
            2'h2: flg2 <= noise_error_bit;
            2'h3: flg2 <= noise_error_bit;
          endcase
        end
      end
      assign flag_out_one_o[i] = flg1;
      assign flag_out_two_o[i] = flg2;
    end
  endgenerate
endmodule
`default_nettype wire

// ===== dqc_host.sv
// Host controller that runs single byte accesses on the counter bus for Wishbone software.
`timescale 1ns/1ps
`default_nettype none
module dqc_host (
  // Clock, clock enable and reset.
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Counter bus.
  dqc_bus_if.host bus
);
  import dqc_pkg::*;

  typedef enum logic [2:0] {DQC_IDLE, DQC_SETUP, DQC_STROBE, DQC_HOLD, DQC_GAP} dqc_state_t;
  dqc_state_t state;
  logic [2:0] cnt;
  logic op_rd;
  logic done;
  logic [7:0] rdata;
  logic go;
  // A command is taken only while idle; later ones are dropped, so poll busy first.
  assign go = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & (wb_adr_i == ADR_CMD)
              & wb_sel_i[1] & (state == DQC_IDLE);

  // Wishbone answer one cycle after the request; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_adr_i == ADR_STAT) begin
        wb_dat_o <= {30'h0, done, state != DQC_IDLE};
      end else if (wb_adr_i == ADR_RDATA) begin
        wb_dat_o <= {24'h000000, rdata};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Access sequencer: select setup, strobe, hold, then the back to back gap.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= DQC_IDLE;
      cnt <= 3'h0;
      op_rd <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      bus.cs_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.cd <= 1'b0;
      bus.xy <= 1'b0;
      bus.host_d <= 8'h00;
      bus.host_oe <= 1'b0;
    end else if (ce_i) begin
      unique case (state)
        DQC_IDLE: begin
          if (go) begin
            op_rd <= wb_dat_i[CMD_RD];
            bus.cd <= wb_dat_i[CMD_CD];
            bus.xy <= wb_dat_i[CMD_XY];
            if (wb_sel_i[0]) begin
              bus.host_d <= wb_dat_i[7:0];
            end
            bus.host_oe <= ~wb_dat_i[CMD_RD];
            bus.cs_n <= 1'b0;
            done <= 1'b0;
            cnt <= 3'(SETUP_CYC - 1);
            state <= DQC_SETUP;
          end
        end
        DQC_SETUP: begin
          if (cnt == 3'h0) begin
            bus.rd_n <= ~op_rd;
            bus.wr_n <= op_rd;
            cnt <= op_rd ? 3'(RD_CYC - 1) : 3'(WR_CYC - 1);
            state <= DQC_STROBE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        DQC_STROBE: begin
          if (cnt == 3'h0) begin
            if (op_rd) begin
              rdata <= bus.data;
            end
            bus.rd_n <= 1'b1;
            bus.wr_n <= 1'b1;
            cnt <= 3'(HOLD_CYC - 1);
            state <= DQC_HOLD;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        DQC_HOLD: begin
          if (cnt == 3'h0) begin
            bus.cs_n <= 1'b1;
            bus.host_oe <= 1'b0;
            cnt <= 3'(B2B_CYC - 1);
            state <= DQC_GAP;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        DQC_GAP: begin
          if (cnt == 3'h0) begin
            done <= 1'b1;
            state <= DQC_IDLE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== dqc_pkg.sv
// Package with shared constants for the dual axis quadrature counter and its host controller.
package dqc_pkg;
  // Clock period and host strobe timing, in nanoseconds.
  localparam int CLK_NS = 25;
  localparam int T_SETUP_NS = 50;
  localparam int T_RD_NS = 50;
  localparam int T_WR_NS = 30;
  localparam int T_HOLD_NS = 10;
  localparam int T_B2B_NS = 60;
  // Least times round up to whole cycles.
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int B2B_CYC = (T_B2B_NS + CLK_NS - 1) / CLK_NS;
  // Control register selects in data bits 6:5; bit 7 targets both axes.
  localparam logic [1:0] SEL_RLC = 2'h0;
  localparam logic [1:0] SEL_CMR = 2'h1;
  localparam logic [1:0] SEL_IOR = 2'h2;
  localparam logic [1:0] SEL_IXS = 2'h3;
  localparam int CTL_BOTH_BIT = 7;
  // Reset/load command bits.
  localparam int RLC_RST_IDX = 0;
  localparam int RLC_RST_CNT = 1;
  localparam int RLC_RST_FLG = 2;
  localparam int RLC_PR_CNT = 3;
  localparam int RLC_CNT_OL = 4;
  // Count modes held in the counter mode register.
  localparam logic [1:0] MODE_NONQ = 2'h0;
  localparam logic [1:0] MODE_X1 = 2'h1;
  localparam logic [1:0] MODE_X2 = 2'h2;
  localparam logic [1:0] MODE_X4 = 2'h3;
  // Input/output register fields.
  localparam int IOR_LD_OL = 0;
  localparam int IOR_GATE = 1;
  localparam int IOR_F1_LSB = 2;
  localparam int IOR_F2_LSB = 4;
  // Index setup register fields.
  localparam int IXS_EN = 0;
  localparam int IXS_POL_HI = 1;
  localparam int IXS_ON_RG = 2;
  // Status byte positions.
  localparam int ST_CARRY = 0;
  localparam int ST_BORROW = 1;
  localparam int ST_CMP = 2;
  localparam int ST_ERR = 4;
  localparam int ST_DIR = 5;
  localparam int ST_IDX = 6;
  // Filter depth: synchroniser pair then three agreeing samples.
  localparam int FILT_LEN = 4;
  // Reset values.
  localparam logic [23:0] CNT_RST = 24'h000000;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [5:0] IOR_RST = 6'h00;
  localparam logic [2:0] IXS_RST = 3'h0;
  localparam logic FLG_RST = 1'b1;
  // Host controller Wishbone map.
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_RDATA = 8'h08;
  localparam int CMD_CD = 8;
  localparam int CMD_XY = 9;
  localparam int CMD_RD = 10;
endpackage

// ===== dqc_sva.sv
// Checker for the counter bus between the host controller and the counter.
`timescale 1ns/1ps
`default_nettype none
module dqc_sva (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus signals.
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cd,
  input wire logic xy,
  input wire logic [7:0] host_d,
  input wire logic host_oe,
  input wire logic dev_oe
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // The device answers a selected read one edge later.
  read_drive_a: assert property (!cs_n && !rd_n |=> dev_oe)
    else $error("read not driven");
  // The device lets go of the bus once the read ends.
  read_release_a: assert property (cs_n || rd_n |=> !dev_oe)
    else $error("bus not released");
  // Two drivers at once would fight on the wire.
  no_contention_a: assert property (!(dev_oe && host_oe))
    else $error("bus contention");
  // Strobes only ever happen under chip select.
  strobe_select_a: assert property (!rd_n || !wr_n |-> !cs_n)
    else $error("strobe without select");
  // Chip select leads the write strobe by two cycles.
  write_setup_a: assert property ($fell(wr_n) |-> !$past(cs_n, 2))
    else $error("select setup short");
  // The write strobe is low for exactly two cycles.
  write_width_a: assert property ($fell(wr_n) |-> ##1 !wr_n ##1 wr_n)
    else $error("write width wrong");
  // Write data is driven and steady while the strobe is low.
  write_data_a: assert property (!wr_n |-> host_oe && $stable(host_d))
    else $error("write data moved");
  // Selects stay put for the whole access.
  select_stable_a: assert property (!cs_n && !$past(cs_n) |->
    $stable(cd) && $stable(xy))
    else $error("select moved");
  // Accesses are parted by three idle cycles.
  access_gap_a: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("gap too short");
  // The host drives data only inside an access.
  host_release_a: assert property (cs_n |-> !host_oe)
    else $error("host drives idle bus");
  // Main scenarios.
  cover property ($rose(wr_n) && !cs_n && cd);
  cover property ($rose(dev_oe) && !cd);
  cover property ($rose(dev_oe) && cd);
endmodule
`default_nettype wire

// ===== dual_axis_quadrature_counter_io_test.sv
// Self-checking bench for the counter and its host controller.
`timescale 1ns/1ps
`default_nettype none
module dual_axis_quadrature_counter_io_test;
  import dqc_pkg::*;
  // Clock, reset and verdict counters.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  // Clock enable, dropped once to show that the X count freezes.
  logic ce = 1'b1;
  int err_count = 0;
  int n_compared = 0;
  // Wishbone master signals.
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [31:0] q;
  // Encoder pins, bit 0 is the X axis; inactive levels at start.
  logic [1:0] a = 2'h0;
  logic [1:0] b = 2'h0;
  logic [1:0] ld_n = 2'h3;
  logic [1:0] rg = 2'h3;
  logic [1:0] f1;
  logic [1:0] f2;
  int c;
  dqc_bus_if bus_if ();
  dqc_dev dqc_dev_i (.clk_i(clk_i), .ce_i(ce), .rst_i(rst_i), .bus(bus_if.dev),
    .count_input_a_i(a), .count_input_b_i(b), .load_index_input_i(ld_n),
    .reset_or_gate_input_i(rg), .flag_out_one_o(f1), .flag_out_two_o(f2));
  dqc_host dqc_host_i (.clk_i(clk_i), .ce_i(ce), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .bus(bus_if.host));
  dqc_sva dqc_sva_i (.clk_i(clk_i), .rst_i(rst_i), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
    .wr_n(bus_if.wr_n), .cd(bus_if.cd), .xy(bus_if.xy), .host_d(bus_if.host_d),
    .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe));
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compares and counts; an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // A missing acknowledge counts as a mismatch.
    chk({31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // One counter bus access; busy is polled since the next command would be ignored.
  task automatic op(input logic rd, input logic cdv, input logic xyv, input logic [7:0] v);
    int n;
    wb(1'b1, ADR_CMD, {21'h0, rd, xyv, cdv, v});
    n = 0;
    do begin
      wb(1'b0, ADR_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    // A controller that stays busy counts as a mismatch.
    chk({31'h0, q[0]}, 32'h0);
    if (rd) begin
      wb(1'b0, ADR_RDATA, 32'h0);
    end
  endtask
  // Copies both counts to the latches and reads one back low byte first.
  task automatic latch(input logic xyv, input logic [23:0] exp);
    logic [23:0] v;
    op(1'b0, 1'b1, 1'b0, 8'h91);
    for (int i = 0; i < 3; i++) begin
      op(1'b1, 1'b0, xyv, 8'h00);
      v[8*i +: 8] = q[7:0];
    end
    chk({8'h0, v}, {8'h0, exp});
  endtask
  // Writes the three load value bytes of one axis.
  task automatic preset(input logic xyv, input logic [23:0] v);
    op(1'b0, 1'b1, xyv, 8'h01);
    for (int i = 0; i < 3; i++) begin
      op(1'b0, 1'b0, xyv, v[8*i +: 8]);
    end
  endtask
  // Pulses count input A; slow enough for any count path.
  task automatic pulse(input int ax, input int n);
    repeat (n) begin
      @(posedge clk_i);
      a[ax] <= 1'b1;
      repeat (4) @(posedge clk_i);
      a[ax] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // One quadrature state on the X axis.
  task automatic qstep(input logic [1:0] ab);
    @(posedge clk_i);
    a[0] <= ab[1];
    b[0] <= ab[0];
    repeat (12) @(posedge clk_i);
  endtask
  // Free running clock.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({30'h0, f1}, 32'h3);
    chk({30'h0, f2}, 32'h3);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    b <= 2'b01;
    pulse(0, 5);
    pulse(1, 3);
    latch(1'b0, 24'h000005);
    latch(1'b1, 24'hFFFFFD);
    op(1'b1, 1'b1, 1'b1, 8'h00);
    chk({31'h0, q[ST_BORROW]}, 32'h1);
    op(1'b1, 1'b1, 1'b0, 8'h00);
    chk({31'h0, q[ST_BORROW]}, 32'h0);
    rg <= 2'b10;
    repeat (2) @(posedge clk_i);
    rg <= 2'b11;
    latch(1'b0, 24'h0);
    op(1'b0, 1'b1, 1'b0, 8'hC2);
    rg <= 2'b00;
    pulse(0, 2);
    latch(1'b0, 24'h0);
    rg <= 2'b11;
    pulse(0, 1);
    latch(1'b0, 24'h1);
    // Pulses while the clock enable is low must not count.
    ce <= 1'b0;
    pulse(0, 2);
    ce <= 1'b1;
    latch(1'b0, 24'h1);
    op(1'b0, 1'b1, 1'b0, 8'hC0);
    preset(1'b0, 24'h123456);
    ld_n <= 2'b10;
    repeat (2) @(posedge clk_i);
    ld_n <= 2'b11;
    latch(1'b0, 24'h123456);
    b <= 2'b00;
    op(1'b0, 1'b1, 1'b0, 8'hA3);
    op(1'b0, 1'b1, 1'b0, 8'h82);
    qstep(2'b10);
    qstep(2'b11);
    qstep(2'b01);
    qstep(2'b00);
    latch(1'b0, 24'h4);
    // Index on the reset input, active low: the first step under it clears the count.
    op(1'b0, 1'b1, 1'b0, 8'hE5);
    rg <= 2'b10;
    qstep(2'b10);
    rg <= 2'b11;
    qstep(2'b11);
    qstep(2'b01);
    qstep(2'b00);
    latch(1'b0, 24'h3);
    op(1'b0, 1'b1, 1'b0, 8'hD4);
    repeat (2) @(posedge clk_i);
    chk({31'h0, f2[0]}, 32'h1);
    preset(1'b0, 24'h000003);
    op(1'b0, 1'b1, 1'b0, 8'h98);
    preset(1'b0, 24'h000004);
    @(posedge clk_i);
    a[0] <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (f1[0] !== 1'b0 && c < 60);
    chk({31'h0, c >= 20 && c <= 28}, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
